// [hw/scfg_pkg.sv]
package scfg_pkg;
    localparam logic [11:0] ADDR_MISC     = 12'h000;
    localparam logic [11:0] ADDR_EXTCTL   = 12'h004;
    localparam logic [11:0] ADDR_INDEX    = 12'h008;
    localparam logic [11:0] ADDR_DATA     = 12'h00c;
    localparam logic [11:0] ADDR_ROMCFG   = 12'h010;
    localparam logic [11:0] ADDR_BUSSTAT  = 12'h014;
    localparam logic [7:0]  IDX_GPSTATUS  = 8'h0f;
    localparam logic [7:0]  STRAP_INV     = 8'hf3;
    localparam int          MISC_SEL_LO   = 2;
    localparam int          MISC_SEL_HI   = 3;
    localparam int          EXT_CLKSEL    = 1;
    localparam int          STRAP_BUS     = 2;
    localparam int          STRAP_CLKOUT  = 3;
    localparam int          ROM_DISABLE   = 0;
    localparam int          ROM_WIDE      = 1;
    localparam logic [1:0]  LOAD_CYCLES   = 2'h2;
    localparam logic [1:0]  SYNC_FILL     = 2'h2;
    localparam logic [1:0]  CLK_IN0       = 2'h0;
    localparam logic [1:0]  CLK_PIN1      = 2'h1;
    localparam logic [1:0]  CLK_PIN2      = 2'h2;
endpackage

// [hw/scfg_clock_select.sv]
`timescale 1ns/1ps
module scfg_clock_select (
    input  wire logic [7:0] miscReg,
    input  wire logic       clkOutMode,
    output logic      [1:0] dotClockSel
);
    always_comb begin
        if (clkOutMode) begin
            dotClockSel = scfg_pkg::CLK_IN0;
        end else if (miscReg[scfg_pkg::MISC_SEL_HI]) begin
            dotClockSel = scfg_pkg::CLK_PIN2;
        end else if (miscReg[scfg_pkg::MISC_SEL_LO]) begin
            dotClockSel = scfg_pkg::CLK_PIN1;
        end else begin
            dotClockSel = scfg_pkg::CLK_IN0;
        end
    end
endmodule

// [hw/strap_config_clock_select.sv]
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module strap_config_clock_select (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  memoryDataPins,
    input  wire logic        romAddrHit,
    input  wire logic        cardSelected,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busIsAt,
    output logic             biosRomDecodeEn,
    output logic             selectFeedbackN,
    output logic             dataSize16N,
    output logic             dotClockPin1Out,
    output logic             dotClockPin1Oe,
    output logic             dotClockPin2Out,
    output logic             dotClockPin2Oe,
    output logic      [1:0]  dotClockSel
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]  mdSync1;
        logic [7:0]  mdSync2;
        logic        captured;
        logic [1:0]  syncFill;
        logic [7:0]  strap;
        logic [1:0]  romCfg;
        logic [7:0]  misc;
        logic [7:0]  extCtl;
        logic [7:0]  index;
        logic [1:0]  loadCnt;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        busAt;
        logic        romEn;
        logic        sfb;
        logic        ds16;
        logic        p1Out;
        logic        p1Oe;
        logic        p2Out;
        logic        p2Oe;
        logic [1:0]  clkSel;
    } scfg_state_t;

    scfg_state_t state_q;
    scfg_state_t state_d;
    logic [1:0]  muxSel;

    function automatic logic addrKnown(input logic [11:0] a);
        addrKnown = (a == scfg_pkg::ADDR_MISC) || (a == scfg_pkg::ADDR_EXTCTL) ||
                    (a == scfg_pkg::ADDR_INDEX) || (a == scfg_pkg::ADDR_DATA) ||
                    (a == scfg_pkg::ADDR_ROMCFG) || (a == scfg_pkg::ADDR_BUSSTAT);
    endfunction

    scfg_clock_select u_sel (
        .miscReg     (state_q.misc),
        .clkOutMode  (state_q.strap[scfg_pkg::STRAP_CLKOUT]),
        .dotClockSel (muxSel)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic access;
    logic complete;
    logic wrMisc;
    logic [7:0] strapNew;
    always_comb begin
        state_d  = state_q;
        access   = psel && penable && !state_q.ready;
        complete = psel && penable && state_q.ready;
        wrMisc   = complete && pwrite && (paddr == scfg_pkg::ADDR_MISC);
        strapNew = state_q.mdSync2 ^ scfg_pkg::STRAP_INV;
        state_d.mdSync1 = memoryDataPins;
        state_d.mdSync2 = state_q.mdSync1;
        // Both sync stages must hold pin levels before the single capture
        if (state_q.syncFill != scfg_pkg::SYNC_FILL) begin
            state_d.syncFill = state_q.syncFill + 2'h1;
        end
        // One capture after release, then frozen until next reset
        if (!state_q.captured && (state_q.syncFill == scfg_pkg::SYNC_FILL)) begin
            state_d.captured = 1'b1;
            state_d.strap    = {strapNew[7:2], 2'h0};
            state_d.romCfg   = strapNew[1:0];
        end
        state_d.ready = access;
        state_d.err   = access && !addrKnown(paddr);
        state_d.rdata = 32'h0;
        // Writes land at the edge where pready is seen high
        if (complete && pwrite) begin
            case (paddr)
                scfg_pkg::ADDR_MISC: begin
                    state_d.misc = pwdata[7:0];
                end
                scfg_pkg::ADDR_EXTCTL: begin
                    state_d.extCtl = pwdata[7:0];
                end
                scfg_pkg::ADDR_INDEX: begin
                    state_d.index = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (access && !pwrite) begin
            case (paddr)
                scfg_pkg::ADDR_MISC: begin
                    state_d.rdata = {24'h0, state_q.misc};
                end
                scfg_pkg::ADDR_EXTCTL: begin
                    state_d.rdata = {24'h0, state_q.extCtl};
                end
                scfg_pkg::ADDR_INDEX: begin
                    state_d.rdata = {24'h0, state_q.index};
                end
                scfg_pkg::ADDR_DATA: begin
                    if (state_q.index == scfg_pkg::IDX_GPSTATUS) begin
                        state_d.rdata = {24'h0, state_q.strap[7:4], 4'h0};
                    end
                end
                scfg_pkg::ADDR_ROMCFG: begin
                    state_d.rdata = {30'h0, state_q.romCfg};
                end
                scfg_pkg::ADDR_BUSSTAT: begin
                    state_d.rdata = {30'h0, muxSel};
                end
                default: begin
                end
            endcase
        end
        // Load pulse on misc write while the clock-output strap is set, stretched over a few cycles
        if (wrMisc && state_q.strap[scfg_pkg::STRAP_CLKOUT]) begin
            state_d.loadCnt = scfg_pkg::LOAD_CYCLES;
        end else if (state_q.loadCnt != 2'h0) begin
            state_d.loadCnt = state_q.loadCnt - 2'h1;
        end
        state_d.busAt = state_q.strap[scfg_pkg::STRAP_BUS];
        state_d.romEn = state_q.captured && !state_q.romCfg[scfg_pkg::ROM_DISABLE];
        if (state_q.strap[scfg_pkg::STRAP_BUS]) begin
            state_d.sfb  = !(state_q.captured && state_q.romCfg[scfg_pkg::ROM_WIDE]);
            state_d.ds16 = 1'b1;
        end else begin
            state_d.sfb  = !cardSelected;
            state_d.ds16 = !(state_q.romCfg[scfg_pkg::ROM_WIDE] && romAddrHit &&
                             state_d.romEn);
        end
        state_d.p1Oe   = state_q.strap[scfg_pkg::STRAP_CLKOUT];
        state_d.p2Oe   = state_q.strap[scfg_pkg::STRAP_CLKOUT];
        state_d.p1Out  = !(state_d.p1Oe && (state_q.loadCnt != 2'h0));
        state_d.p2Out  = state_q.extCtl[scfg_pkg::EXT_CLKSEL];
        state_d.clkSel = muxSel;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= '0;
            state_q.busAt <= 1'b1;
            state_q.sfb   <= 1'b1;
            state_q.ds16  <= 1'b1;
            state_q.p1Out <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata          = state_q.rdata;
    assign pready          = state_q.ready;
    assign pslverr         = state_q.err;
    assign busIsAt         = state_q.busAt;
    assign biosRomDecodeEn = state_q.romEn;
    assign selectFeedbackN = state_q.sfb;
    assign dataSize16N     = state_q.ds16;
    assign dotClockPin1Out = state_q.p1Out;
    assign dotClockPin1Oe  = state_q.p1Oe;
    assign dotClockPin2Out = state_q.p2Out;
    assign dotClockPin2Oe  = state_q.p2Oe;
    assign dotClockSel     = state_q.clkSel;

    ////////////////////////////////////////////////////////////////////////////
    property p_strapHold;
        @(posedge clk) disable iff (!rstn)
        state_q.captured |=> $stable(state_q.strap) && $stable(state_q.romCfg);
    endproperty
    a_strapHold: assert property (p_strapHold) else $error("strap changed");

    property p_pinDir;
        @(posedge clk) disable iff (!rstn)
        ##1 (dotClockPin1Oe == $past(state_q.strap[scfg_pkg::STRAP_CLKOUT])) &&
            (dotClockPin2Oe == dotClockPin1Oe);
    endproperty
    a_pinDir: assert property (p_pinDir) else $error("clock pin direction wrong");

    property p_lockIn0;
        @(posedge clk) disable iff (!rstn)
        state_q.strap[scfg_pkg::STRAP_CLKOUT] |=> dotClockSel == scfg_pkg::CLK_IN0;
    endproperty
    a_lockIn0: assert property (p_lockIn0) else $error("mux not locked");

    property p_selPin2;
        @(posedge clk) disable iff (!rstn)
        (!state_q.strap[scfg_pkg::STRAP_CLKOUT] && state_q.misc[scfg_pkg::MISC_SEL_HI])
            |=> dotClockSel == scfg_pkg::CLK_PIN2;
    endproperty
    a_selPin2: assert property (p_selPin2) else $error("pin2 not selected");

    property p_loadPulse;
        @(posedge clk) disable iff (!rstn)
        (psel && penable && pwrite && pready && paddr == scfg_pkg::ADDR_MISC &&
         state_q.strap[scfg_pkg::STRAP_CLKOUT])
            |=> ##1 !dotClockPin1Out [*2];
    endproperty
    a_loadPulse: assert property (p_loadPulse) else $error("no load pulse");

    property p_pin2Level;
        @(posedge clk) disable iff (!rstn)
        ##1 dotClockPin2Out == $past(state_q.extCtl[scfg_pkg::EXT_CLKSEL]);
    endproperty
    a_pin2Level: assert property (p_pin2Level) else $error("pin2 level wrong");

    property p_statusRead;
        @(posedge clk) disable iff (!rstn)
        (psel && penable && !pwrite && !pready && paddr == scfg_pkg::ADDR_DATA &&
         state_q.index == scfg_pkg::IDX_GPSTATUS)
            |=> prdata == {24'h0, state_q.strap[7:4], 4'h0};
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status read wrong");

    property p_atFeedback;
        @(posedge clk) disable iff (!rstn)
        (state_q.captured && state_q.strap[scfg_pkg::STRAP_BUS] &&
         state_q.romCfg[scfg_pkg::ROM_WIDE]) |=> !selectFeedbackN;
    endproperty
    a_atFeedback: assert property (p_atFeedback) else $error("feedback not low");

    property p_mcaSize;
        @(posedge clk) disable iff (!rstn)
        (state_q.captured && !state_q.strap[scfg_pkg::STRAP_BUS] && !dataSize16N) |->
            $past(state_q.romCfg[scfg_pkg::ROM_WIDE] && romAddrHit);
    endproperty
    a_mcaSize: assert property (p_mcaSize) else $error("size16 without cause");

    property p_strapPolarity;
        @(posedge clk) disable iff (!rstn)
        (!state_q.captured && (state_q.syncFill == scfg_pkg::SYNC_FILL)) |=>
            (state_q.strap[scfg_pkg::STRAP_BUS] ==
             $past(state_q.mdSync2[scfg_pkg::STRAP_BUS])) &&
            (state_q.romCfg[scfg_pkg::ROM_WIDE] !=
             $past(state_q.mdSync2[scfg_pkg::ROM_WIDE]));
    endproperty
    a_strapPolarity: assert property (p_strapPolarity) else $error("strap polarity wrong");

    property p_romDecode;
        @(posedge clk) disable iff (!rstn)
        state_q.captured |=>
            biosRomDecodeEn != $past(state_q.romCfg[scfg_pkg::ROM_DISABLE]);
    endproperty
    a_romDecode: assert property (p_romDecode) else $error("rom decode wrong");

    property p_busMode;
        @(posedge clk) disable iff (!rstn)
        state_q.captured |=> busIsAt == $past(state_q.strap[scfg_pkg::STRAP_BUS]);
    endproperty
    a_busMode: assert property (p_busMode) else $error("bus mode wrong");

    property p_mcaFeedback;
        @(posedge clk) disable iff (!rstn)
        (state_q.captured && !state_q.strap[scfg_pkg::STRAP_BUS]) |=>
            selectFeedbackN != $past(cardSelected);
    endproperty
    a_mcaFeedback: assert property (p_mcaFeedback) else $error("card feedback wrong");

    property p_atSize;
        @(posedge clk) disable iff (!rstn)
        (state_q.captured && state_q.strap[scfg_pkg::STRAP_BUS]) |=> dataSize16N;
    endproperty
    a_atSize: assert property (p_atSize) else $error("size16 active in AT mode");

    property p_size16Hit;
        @(posedge clk) disable iff (!rstn)
        (state_q.captured && !state_q.strap[scfg_pkg::STRAP_BUS] && romAddrHit &&
         state_q.romCfg[scfg_pkg::ROM_WIDE] && !state_q.romCfg[scfg_pkg::ROM_DISABLE])
            |=> !dataSize16N;
    endproperty
    a_size16Hit: assert property (p_size16Hit) else $error("size16 missing on rom hit");

    property p_selPin1;
        @(posedge clk) disable iff (!rstn)
        (!state_q.strap[scfg_pkg::STRAP_CLKOUT] && !state_q.misc[scfg_pkg::MISC_SEL_HI] &&
         state_q.misc[scfg_pkg::MISC_SEL_LO]) |=> dotClockSel == scfg_pkg::CLK_PIN1;
    endproperty
    a_selPin1: assert property (p_selPin1) else $error("pin1 not selected");

    property p_selIn0;
        @(posedge clk) disable iff (!rstn)
        (!state_q.strap[scfg_pkg::STRAP_CLKOUT] && !state_q.misc[scfg_pkg::MISC_SEL_HI] &&
         !state_q.misc[scfg_pkg::MISC_SEL_LO]) |=> dotClockSel == scfg_pkg::CLK_IN0;
    endproperty
    a_selIn0: assert property (p_selIn0) else $error("input 0 not selected");

    property p_pin1Idle;
        @(posedge clk) disable iff (!rstn)
        !state_q.strap[scfg_pkg::STRAP_CLKOUT] |=> dotClockPin1Out;
    endproperty
    a_pin1Idle: assert property (p_pin1Idle) else $error("load pulse while inputs");

    property p_statusLow;
        @(posedge clk) disable iff (!rstn)
        (psel && penable && !pwrite && !pready && paddr == scfg_pkg::ADDR_DATA) |=>
            prdata[scfg_pkg::STRAP_CLKOUT:scfg_pkg::STRAP_BUS] == 2'h0;
    endproperty
    a_statusLow: assert property (p_statusLow) else $error("hidden straps readable");
endmodule

// [test/scfg_board_model.sv]
`timescale 1ns/1ps
module scfg_board_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] pullUp,
    input  wire logic       busDrive,
    input  wire logic [7:0] busData,
    output logic      [7:0] memoryDataPins,
    input  wire logic       dotClockPin1Out,
    input  wire logic       dotClockPin1Oe,
    output int              loadLowCycles
);
    // Pins rest at the resistor level whenever no memory traffic drives them
    assign memoryDataPins = busDrive ? busData : pullUp;
    // Clock chip load strobe: width of every low pulse is summed in cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loadLowCycles <= 0;
        end else if (dotClockPin1Oe && !dotClockPin1Out) begin
            loadLowCycles <= loadLowCycles + 1;
        end
    end
endmodule

// [test/strap_config_clock_select_tb.sv]
`timescale 1ns/1ps
module strap_config_clock_select_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  pullUp = 8'h00;
    logic        busDrive = 1'b0;
    logic [7:0]  memoryDataPins;
    logic        romAddrHit = 1'b0;
    logic        cardSelected = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, busIsAt, biosRomDecodeEn, selectFeedbackN;
    logic        dataSize16N, dotClockPin1Out, dotClockPin1Oe, dotClockPin2Out;
    logic        dotClockPin2Oe;
    logic [1:0]  dotClockSel;
    int          loadLowCycles;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          c;
    logic [31:0] rdata;
    logic        rerr;
    logic [15:0] row;
    // Pins, status nibble, AT, clock outputs, ROM config bits
    logic [15:0] rows [4] = '{16'h0cff, 16'hf300, 16'h59a6, 16'ha55a};

    always #2 clk = ~clk;

    strap_config_clock_select i_dut (
        .clk             (clk),
        .rstn            (rstn),
        .memoryDataPins  (memoryDataPins),
        .romAddrHit      (romAddrHit),
        .cardSelected    (cardSelected),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .busIsAt         (busIsAt),
        .biosRomDecodeEn (biosRomDecodeEn),
        .selectFeedbackN (selectFeedbackN),
        .dataSize16N     (dataSize16N),
        .dotClockPin1Out (dotClockPin1Out),
        .dotClockPin1Oe  (dotClockPin1Oe),
        .dotClockPin2Out (dotClockPin2Out),
        .dotClockPin2Oe  (dotClockPin2Oe),
        .dotClockSel     (dotClockSel)
    );

    scfg_board_model i_board (.clk(clk), .rstn(rstn), .pullUp(pullUp),
        .busDrive(busDrive), .busData(8'h3c), .memoryDataPins(memoryDataPins),
        .dotClockPin1Out(dotClockPin1Out), .dotClockPin1Oe(dotClockPin1Oe),
        .loadLowCycles(loadLowCycles));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            conclude();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (rows[k]) begin
            row = rows[k];
            pullUp <= row[15:8];
            rstn <= 1'b0;
            repeat (16) @(posedge clk);
            rstn <= 1'b1;
            // Two sync stages, the capture and the output register must pass
            repeat (8) @(posedge clk);
            chk(busIsAt, row[3]);
            chk(dotClockPin1Oe, row[2]);
            chk(dotClockPin2Oe, row[2]);
            chk(biosRomDecodeEn, !row[0]);
            apb(1'b0, scfg_pkg::ADDR_ROMCFG, 32'h0);
            chk(rdata, {30'h0, row[1:0]});
            apb(1'b1, scfg_pkg::ADDR_INDEX, {24'h0, scfg_pkg::IDX_GPSTATUS});
            apb(1'b0, scfg_pkg::ADDR_DATA, 32'h0);
            chk(rdata, {24'h0, row[7:4], 4'h0});
            cardSelected <= 1'b1;
            romAddrHit <= 1'b1;
            repeat (3) @(posedge clk);
            chk(selectFeedbackN, row[3] ? !row[1] : 1'b0);
            chk(dataSize16N, !(!row[3] && row[1] && !row[0]));
            romAddrHit <= 1'b0;
            cardSelected <= 1'b0;
            repeat (3) @(posedge clk);
            chk(dataSize16N, 1'b1);
            chk(selectFeedbackN, row[3] ? !row[1] : 1'b1);
            for (c = 0; c < 4; c++) begin
                apb(1'b1, scfg_pkg::ADDR_MISC, 32'(c << 2));
                repeat (4) @(posedge clk);
                chk(dotClockSel, row[2] ? scfg_pkg::CLK_IN0 :
                    c[1] ? scfg_pkg::CLK_PIN2 :
                    c[0] ? scfg_pkg::CLK_PIN1 : scfg_pkg::CLK_IN0);
            end
            apb(1'b0, scfg_pkg::ADDR_BUSSTAT, 32'h0);
            chk(rdata, {30'h0, row[2] ? scfg_pkg::CLK_IN0 : scfg_pkg::CLK_PIN2});
            chk(loadLowCycles, row[2] ? 4 * scfg_pkg::LOAD_CYCLES : 0);
            for (c = 1; c >= 0; c--) begin
                apb(1'b1, scfg_pkg::ADDR_EXTCTL, 32'(c << 1));
                repeat (2) @(posedge clk);
                if (row[2]) chk(dotClockPin2Out, c[0]);
            end
        end
        // Memory traffic after reset must leave the latched straps alone
        busDrive <= 1'b1;
        repeat (10) @(posedge clk);
        apb(1'b0, scfg_pkg::ADDR_DATA, 32'h0);
        chk(rdata, 32'h50);
        chk(busIsAt, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 1'b1);
        chk(rdata, 32'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk(dotClockPin1Out, 1'b1);
        chk(dotClockPin1Oe, 1'b0);
        chk(dotClockSel, scfg_pkg::CLK_IN0);
        conclude();
    end
endmodule
